// *** codec_cmd_pkg.sv ***
// Command codes, field positions, reset values and counts of the codec setup block
package codec_cmd_pkg;

    localparam int NUM_CH = 4;

    // Command codes; the low bit of a register command is the read flag
    localparam logic [7:0] CMD_NOP = 8'h06;
    localparam logic [7:0] CMD_ACTIVATE = 8'h0e;
    localparam logic [7:0] CMD_TX_SLOT_WR = 8'h40;
    localparam logic [7:0] CMD_TX_SLOT_RD = 8'h41;
    localparam logic [7:0] CMD_RX_SLOT_WR = 8'h42;
    localparam logic [7:0] CMD_RX_SLOT_RD = 8'h43;
    localparam logic [7:0] CMD_CLK_SLOT_WR = 8'h44;
    localparam logic [7:0] CMD_CLK_SLOT_RD = 8'h45;
    localparam logic [7:0] CMD_CFG_WR = 8'h46;
    localparam logic [7:0] CMD_CFG_RD = 8'h47;
    localparam logic [7:0] CMD_EN_WR = 8'h4a;
    localparam logic [7:0] CMD_EN_RD = 8'h4b;

    // Reset values
    localparam logic [7:0] SLOT_RST [NUM_CH] = '{8'h00, 8'h01, 8'h02, 8'h03};
    localparam logic [7:0] CLK_SLOT_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'h9a;
    localparam logic [7:0] EN_RST = 8'h0f;

    // Slot byte fields
    localparam int HWY_BIT = 7;
    localparam int TS_MSB = 6;
    // Clock slot byte fields
    localparam int DUAL_BIT = 7;
    localparam int EDGE_BIT = 6;
    localparam int RCS_LSB = 3;
    localparam int TCS_LSB = 0;
    // Configuration byte fields
    localparam int IRQ_STYLE_BIT = 7;
    localparam int CHOP_BIT = 6;
    localparam int SIG_BIT = 5;
    localparam int SRC_BIT = 4;
    localparam int MASTER_CLK_RATE_SEL_MSB = 3;
    // Channel enable byte fields
    localparam int RBE_BIT = 6;
    localparam int IDLE_BIT = 5;
    localparam int LP_BIT = 4;

    // Serial framing and timing counts
    localparam logic [4:0] MIN_EDGES = 5'd8;
    localparam logic [4:0] RESET_EDGES = 5'd16;
    localparam logic [1:0] FS_WAIT = 2'd2;

    // Master clock base rates and chopper divisors
    localparam logic [13:0] RATE_1536_KHZ = 14'd1536;
    localparam logic [13:0] RATE_1544_KHZ = 14'd1544;
    localparam logic [13:0] RATE_2048_KHZ = 14'd2048;
    localparam logic [3:0] CHOP_DIV_SLOW = 4'd8;
    localparam logic [3:0] CHOP_DIV_FAST = 4'd7;

    typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ} seq_state_t;

endpackage : codec_cmd_pkg

// *** bit_sync.sv ***
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module bit_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Pins and synchronised copies
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_q <= RST_VAL;
            sync_out <= RST_VAL;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : bit_sync

// *** chan_slot_reg.sv ***
// One channel's time slot and highway byte with its own reset value
`timescale 1ns/1ps
module chan_slot_reg #(
    parameter logic [7:0] RST_VAL = 8'h00
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Serial-commanded restore of the default value
    input wire logic restore,
    // Write port and stored byte
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    output logic [7:0] q
);
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            q <= RST_VAL;
        else if (restore)
            q <= RST_VAL;
        else if (wr_en)
            q <= wr_data;
    end
endmodule : chan_slot_reg

// *** codec_setup.sv ***
// Serial command interpreter for slot, clock, configuration and channel setup
`timescale 1ns/1ps
// Summary of operation
// - Activate code sets enabled channels active and raises their active flag.
// - After activation, PCM samples are valid only after the second frame sync.
// - Transmit slot byte per channel: bit 7 highway, bits 6..0 slot number.
// - Highway bit zero sends on A, one sends on B, unless dual mode overrides.
// - Receive slot byte per channel: bit 7 highway, bits 6..0 slot number.
// - Reset puts slot bytes 00h, 01h, 02h, 03h on channels one to four.
// - Clock byte: dual bit 7, edge bit 6, receive slot 5..3, transmit 2..0.
// - Dual bit clear sends on selected highway only; set sends on both.
// - Edge bit zero changes output on falling clock, one on rising.
// - Clock byte is shared; its access is ignored when no channel is enabled.
// - Configuration bit 6 picks chopper divisor eight or seven of 2048 kHz.
// - Configuration bit 5 enables signaling on the PCM highway.
// - Configuration bit 4 picks master clock source and allows E1 multiplexing.
// - Clock select: low bits pick base rate, high bits the multiplier.
// - Configuration access works whatever the channel enables are.
// - Enable byte bits 3..0 gate channel commands; bit 7 reserved.
// - Enable bit 6 turns on robbed-bit receive signaling, only under mu-law.
// - Enable bit 5 picks resistor-to-reference or high impedance idle output.
// - Enable bit 4 allows low power while every channel is inactive.
// - Under 8 edges ignored, 8 to 15 keep last 8, 16 or more reset.
module codec_setup (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Host serial port pins
    input wire logic host_cs_n,
    input wire logic host_data_clock,
    input wire logic host_din,
    output logic host_dout,
    output logic host_dout_oe,
    // PCM timing pin and coding state from the codec core
    input wire logic frame_sync,
    input wire logic mu_law_sel,
    // Per-channel slot setup, four bytes packed channel one lowest
    output logic [8*codec_cmd_pkg::NUM_CH-1:0] tx_slot_byte,
    output logic [8*codec_cmd_pkg::NUM_CH-1:0] rx_slot_byte,
    output logic [codec_cmd_pkg::NUM_CH-1:0] tx_hwy_a_en,
    output logic [codec_cmd_pkg::NUM_CH-1:0] tx_hwy_b_en,
    output logic [codec_cmd_pkg::NUM_CH-1:0] rx_highway_sel,
    // Shared clock slot setup
    output logic tx_edge_sel,
    output logic [2:0] rx_clock_slot,
    output logic [2:0] tx_clock_slot,
    // Global configuration
    output logic irq_output_style,
    output logic chopper_rate_sel,
    output logic [3:0] chopper_divisor,
    output logic highway_signaling_en,
    output logic master_clk_source,
    output logic e1_mux_allowed,
    output logic [3:0] master_clk_rate_sel,
    output logic [13:0] master_clk_khz,
    output logic master_clk_sel_bad,
    // Channel enable and operating mode
    output logic [codec_cmd_pkg::NUM_CH-1:0] chan_cmd_en,
    output logic robbed_bit_en,
    output logic robbed_bit_active,
    output logic idle_output_style,
    output logic [codec_cmd_pkg::NUM_CH-1:0] analog_out_hiz,
    output logic low_power_en,
    output logic low_power_mode,
    // Channel state
    output logic [codec_cmd_pkg::NUM_CH-1:0] channel_active_flag,
    output logic [codec_cmd_pkg::NUM_CH-1:0] tx_pcm_valid
);
    import codec_cmd_pkg::*;

    logic cs_n_s;
    logic host_data_clock_s;
    logic din_s;
    logic cs_n_prev_q;
    logic host_data_clock_prev_q;
    logic fs_s;
    logic fs_prev_q;
    logic [7:0] shin_q;
    logic [4:0] edge_cnt_q;
    logic [7:0] out_q;
    seq_state_t state_q;
    seq_state_t state_d;
    logic [7:0] cmd_q;
    logic [7:0] cmd_d;
    logic [2:0] ptr_q;
    logic [2:0] ptr_d;
    logic [7:0] clk_slot_q;
    logic [7:0] cfg_q;
    logic [7:0] en_q;
    logic [NUM_CH-1:0] active_q;
    logic [1:0] fs_cnt_q [NUM_CH];
    logic [7:0] rd_val;

    // Pins are asynchronous to ref_clk; the host clock is sampled, not used as a clock
    bit_sync #(
        .WIDTH(4),
        // Idle pin levels, so that no false edge follows reset
        .RST_VAL(4'b1100)
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .async_in({host_cs_n, host_data_clock, host_din, frame_sync}),
        .sync_out({cs_n_s, host_data_clock_s, din_s, fs_s})
    );

    // Edge detection on synchronised pins
    wire host_data_clock_rise = host_data_clock_s & ~host_data_clock_prev_q;
    wire cs_fall = ~cs_n_s & cs_n_prev_q;
    wire cs_rise = cs_n_s & ~cs_n_prev_q;
    wire fs_rise = fs_s & ~fs_prev_q;
    wire shift_edge = host_data_clock_rise & ~cs_n_s;
    wire byte_evt = cs_rise & (edge_cnt_q >= MIN_EDGES) & (edge_cnt_q < RESET_EDGES);
    wire hw_reset_evt = cs_rise & (edge_cnt_q >= RESET_EDGES);

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cs_n_prev_q <= 1'b1;
            host_data_clock_prev_q <= 1'b1;
            fs_prev_q <= 1'b0;
        end
        else
        begin
            cs_n_prev_q <= cs_n_s;
            host_data_clock_prev_q <= host_data_clock_s;
            fs_prev_q <= fs_s;
        end
    end

    // Only the last eight bits survive the shift; the count saturates at the reset mark
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            shin_q <= 8'h00;
            edge_cnt_q <= 5'd0;
        end
        else if (cs_fall)
            edge_cnt_q <= 5'd0;
        else if (shift_edge)
        begin
            shin_q <= {shin_q[6:0], din_s};
            if (edge_cnt_q < RESET_EDGES)
                edge_cnt_q <= edge_cnt_q + 5'd1;
        end
    end

    // Command decode
    wire any_en = |en_q[NUM_CH-1:0];
    wire idle = (state_q == ST_IDLE);
    wire is_chan_cmd = (shin_q[7:2] == CMD_TX_SLOT_WR[7:2]);
    wire is_clk_cmd = (shin_q[7:1] == CMD_CLK_SLOT_WR[7:1]);
    wire is_cfg_cmd = (shin_q[7:1] == CMD_CFG_WR[7:1]);
    wire is_en_cmd = (shin_q[7:1] == CMD_EN_WR[7:1]);
    // Clock slot access needs an enabled channel, configuration never does
    wire cmd_accept = (is_chan_cmd & any_en) | (is_clk_cmd & any_en)
        | is_cfg_cmd | is_en_cmd;
    wire start_seq = byte_evt & idle & cmd_accept;
    wire act_evt = byte_evt & idle & (shin_q == CMD_ACTIVATE);
    wire global_cmd = (cmd_q[7:2] != CMD_TX_SLOT_WR[7:2]);

    function automatic logic [2:0] next_chan(input logic [NUM_CH-1:0] mask,
                                             input logic [2:0] from);
        logic [2:0] r;
        r = 3'(NUM_CH);
        for (int i = NUM_CH - 1; i >= 0; i--)
        begin
            if (mask[i] && (i >= int'(from)))
                r = 3'(i);
        end
        return r;
    endfunction : next_chan

    wire [2:0] first_ch = next_chan(en_q[NUM_CH-1:0], 3'd0);
    wire [2:0] following_ch = next_chan(en_q[NUM_CH-1:0], ptr_q + 3'd1);
    wire seq_last = global_cmd | (following_ch == 3'(NUM_CH));
    wire data_evt = byte_evt & ~idle;

    always_comb
    begin
        state_d = state_q;
        cmd_d = cmd_q;
        ptr_d = ptr_q;
        case (state_q)
            ST_IDLE:
            begin
                if (start_seq)
                begin
                    cmd_d = shin_q;
                    ptr_d = first_ch;
                    state_d = shin_q[0] ? ST_READ : ST_WRITE;
                end
            end
            ST_WRITE, ST_READ:
            begin
                if (data_evt)
                begin
                    ptr_d = following_ch;
                    if (seq_last)
                        state_d = ST_IDLE;
                end
            end
            default:
                state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= ST_IDLE;
            cmd_q <= CMD_NOP;
            ptr_q <= 3'd0;
        end
        else if (hw_reset_evt)
            state_q <= ST_IDLE;
        else
        begin
            state_q <= state_d;
            cmd_q <= cmd_d;
            ptr_q <= ptr_d;
        end
    end

    // Register writes from data bytes
    wire wr_evt = data_evt & (state_q == ST_WRITE);
    wire clk_wr = wr_evt & (cmd_q == CMD_CLK_SLOT_WR);
    wire cfg_wr = wr_evt & (cmd_q == CMD_CFG_WR);
    wire en_wr = wr_evt & (cmd_q == CMD_EN_WR);

    logic [7:0] tx_slot [NUM_CH];
    logic [7:0] rx_slot [NUM_CH];

    for (genvar ch = 0; ch < NUM_CH; ch++)
    begin : g_chan
        wire hit = wr_evt & (ptr_q == 3'(ch));
        chan_slot_reg #(
            .RST_VAL(SLOT_RST[ch])
        ) u_tx_slot (
            .ref_clk(ref_clk),
            .resetn(resetn),
            .restore(hw_reset_evt),
            .wr_en(hit & (cmd_q == CMD_TX_SLOT_WR)),
            .wr_data(shin_q),
            .q(tx_slot[ch])
        );
        chan_slot_reg #(
            .RST_VAL(SLOT_RST[ch])
        ) u_rx_slot (
            .ref_clk(ref_clk),
            .resetn(resetn),
            .restore(hw_reset_evt),
            .wr_en(hit & (cmd_q == CMD_RX_SLOT_WR)),
            .wr_data(shin_q),
            .q(rx_slot[ch])
        );
        assign tx_slot_byte[8*ch +: 8] = tx_slot[ch];
        assign rx_slot_byte[8*ch +: 8] = rx_slot[ch];
        assign rx_highway_sel[ch] = rx_slot[ch][HWY_BIT];
        // Dual mode forces both highways regardless of the per-channel choice
        assign tx_hwy_a_en[ch] = ~tx_slot[ch][HWY_BIT] | clk_slot_q[DUAL_BIT];
        assign tx_hwy_b_en[ch] = tx_slot[ch][HWY_BIT] | clk_slot_q[DUAL_BIT];
        assign tx_pcm_valid[ch] = active_q[ch] & (fs_cnt_q[ch] == FS_WAIT);
    end

    // Bit 7 of the enable byte is reserved and kept at zero
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            clk_slot_q <= CLK_SLOT_RST;
            cfg_q <= CFG_RST;
            en_q <= EN_RST;
        end
        else if (hw_reset_evt)
        begin
            clk_slot_q <= CLK_SLOT_RST;
            cfg_q <= CFG_RST;
            en_q <= EN_RST;
        end
        else
        begin
            if (clk_wr)
                clk_slot_q <= shin_q;
            if (cfg_wr)
                cfg_q <= shin_q;
            if (en_wr)
                en_q <= {1'b0, shin_q[6:0]};
        end
    end

    // Activation and frame sync counting per channel
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            active_q <= '0;
            fs_cnt_q <= '{default: 2'd0};
        end
        else if (hw_reset_evt)
            active_q <= '0;
        else
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                if (act_evt && en_q[i])
                begin
                    active_q[i] <= 1'b1;
                    fs_cnt_q[i] <= 2'd0;
                end
                else if (fs_rise && fs_cnt_q[i] != FS_WAIT)
                    fs_cnt_q[i] <= fs_cnt_q[i] + 2'd1;
            end
        end
    end

    // Read data selection
    always_comb
    begin
        rd_val = 8'h00;
        case (cmd_q)
            CMD_TX_SLOT_RD: rd_val = tx_slot[ptr_q[1:0]];
            CMD_RX_SLOT_RD: rd_val = rx_slot[ptr_q[1:0]];
            CMD_CLK_SLOT_RD: rd_val = clk_slot_q;
            CMD_CFG_RD: rd_val = cfg_q;
            CMD_EN_RD: rd_val = en_q;
            default: rd_val = 8'h00;
        endcase
    end

    // Read byte loads as select falls and shifts out MSB first on each rising edge
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            out_q <= 8'h00;
        else if (cs_fall && state_q == ST_READ)
            out_q <= rd_val;
        else if (shift_edge)
            out_q <= {out_q[6:0], 1'b0};
    end

    assign host_dout = out_q[7];
    assign host_dout_oe = ~cs_n_s & (state_q == ST_READ);

    // Shared clock and configuration fields
    assign tx_edge_sel = clk_slot_q[EDGE_BIT];
    assign rx_clock_slot = clk_slot_q[RCS_LSB +: 3];
    assign tx_clock_slot = clk_slot_q[TCS_LSB +: 3];
    assign irq_output_style = cfg_q[IRQ_STYLE_BIT];
    assign chopper_rate_sel = cfg_q[CHOP_BIT];
    assign chopper_divisor = chopper_rate_sel ? CHOP_DIV_FAST : CHOP_DIV_SLOW;
    assign highway_signaling_en = cfg_q[SIG_BIT];
    assign master_clk_source = cfg_q[SRC_BIT];
    assign e1_mux_allowed = master_clk_source;
    assign master_clk_rate_sel = cfg_q[MASTER_CLK_RATE_SEL_MSB:0];

    // Reserved codes read back as stored but report a zero rate
    wire [1:0] base_code = master_clk_rate_sel[1:0];
    wire [1:0] mult_code = master_clk_rate_sel[3:2];
    wire [13:0] base_khz = (base_code == 2'd0) ? RATE_1536_KHZ :
                           (base_code == 2'd1) ? RATE_1544_KHZ : RATE_2048_KHZ;
    assign master_clk_sel_bad = (base_code == 2'd3) | (mult_code == 2'd3);
    assign master_clk_khz = master_clk_sel_bad ? 14'd0 : (base_khz << mult_code);

    // Channel enable and operating mode fields
    assign chan_cmd_en = en_q[NUM_CH-1:0];
    assign robbed_bit_en = en_q[RBE_BIT];
    assign robbed_bit_active = robbed_bit_en & mu_law_sel;
    assign idle_output_style = en_q[IDLE_BIT];
    assign analog_out_hiz = {NUM_CH{idle_output_style}} & ~active_q;
    assign low_power_en = en_q[LP_BIT];
    assign low_power_mode = low_power_en & ~|active_q;
    assign channel_active_flag = active_q;

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_nop_taken;
        byte_evt && idle && (shin_q == CMD_NOP);
    endsequence

    a_nop_no_change: assert property (
        s_nop_taken |=> $stable(cfg_q) && $stable(en_q) && $stable(active_q)
            && $stable(clk_slot_q) && (state_q == ST_IDLE))
        else $error("no-operation changed state");

    a_activate_sets: assert property (
        act_evt |=> ((active_q & $past(en_q[NUM_CH-1:0])) == $past(en_q[NUM_CH-1:0])))
        else $error("activate did not set enabled channels");

    // Frame syncs seen by channel one since its last activation; the count stops at FS_WAIT
    logic [1:0] chk_fs_q;
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            chk_fs_q <= 2'd0;
        else if (act_evt && en_q[0])
            chk_fs_q <= 2'd0;
        else if (fs_rise && (chk_fs_q != FS_WAIT))
            chk_fs_q <= chk_fs_q + 2'd1;
    end

    a_pcm_wait_fs: assert property (
        tx_pcm_valid[0] |-> (chk_fs_q == FS_WAIT))
        else $error("pcm valid before second frame sync");

    a_hwy_select: assert property (
        !clk_slot_q[DUAL_BIT] |-> (tx_hwy_a_en[0] != tx_hwy_b_en[0])
            && (tx_hwy_b_en[0] == tx_slot_byte[HWY_BIT]))
        else $error("highway enable mismatch");

    a_dual_both: assert property (
        clk_slot_q[DUAL_BIT] |-> (&tx_hwy_a_en) && (&tx_hwy_b_en))
        else $error("dual mode not on both highways");

    a_clk_slot_gate: assert property (
        (byte_evt && idle && is_clk_cmd && !any_en) |=> (state_q == ST_IDLE) && $stable(clk_slot_q))
        else $error("clock slot access taken with no channel enabled");

    a_cfg_write: assert property (
        (data_evt && (state_q == ST_WRITE) && (cmd_q == CMD_CFG_WR))
            |=> (cfg_q == $past(shin_q)) && (state_q == ST_IDLE))
        else $error("configuration write lost");

    a_short_frame: assert property (
        (cs_rise && edge_cnt_q < MIN_EDGES) |=> $stable(state_q) && $stable(cfg_q) && $stable(en_q))
        else $error("short select period had an effect");

    a_long_reset: assert property (
        hw_reset_evt |=> (cfg_q == CFG_RST) && (en_q == EN_RST) && (active_q == '0)
            && (tx_slot_byte[15:8] == SLOT_RST[1]))
        else $error("long select period did not reset");

    a_low_power: assert property (
        low_power_mode |-> low_power_en && (channel_active_flag == '0))
        else $error("low power while a channel is active");

endmodule : codec_setup

// *** host_model.sv ***
// Host processor model driving the serial command pins
`timescale 1ns/1ps
module host_model (
    // Clock
    input wire logic ref_clk,
    // Serial pins
    output logic host_cs_n,
    output logic host_data_clock,
    output logic host_din,
    input wire logic host_dout
);
    initial
    begin
        host_cs_n = 1'b1;
        host_data_clock = 1'b1;
        host_din = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : wait_clk
    // Drop select ahead of a transfer, so the read driver can be watched
    task automatic select_low;
        host_cs_n = 1'b0;
        wait_clk(6);
    endtask : select_low
    // One select period; leading extra bits are dropped by the device
    task automatic xfer(input logic [15:0] tx, input int edges, output logic [7:0] rx);
        host_cs_n = 1'b0;
        wait_clk(8);
        for (int i = edges - 1; i >= 0; i--)
        begin
            host_data_clock = 1'b0;
            host_din = tx[i];
            wait_clk(6);
            rx = {rx[6:0], host_dout};
            host_data_clock = 1'b1;
            wait_clk(6);
        end
        host_cs_n = 1'b1;
        // A released line must not keep showing the last bit
        host_din = ~host_din;
        wait_clk(8);
    endtask : xfer
endmodule : host_model

// *** tb_codec_setup.sv ***
// Self-checking testbench for the codec setup command block
`timescale 1ns/1ps
module tb_codec_setup;
    import codec_cmd_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic frame_sync = 1'b0;
    logic mu_law_sel = 1'b0;
    logic host_cs_n, host_data_clock, host_din, host_dout, host_dout_oe;
    logic [31:0] tx_slot_byte, rx_slot_byte;
    logic [3:0] tx_hwy_a_en, tx_hwy_b_en, rx_highway_sel, chan_cmd_en, analog_out_hiz;
    logic [3:0] channel_active_flag, tx_pcm_valid, chopper_divisor, master_clk_rate_sel;
    logic [2:0] rx_clock_slot, tx_clock_slot;
    logic [13:0] master_clk_khz;
    logic tx_edge_sel, irq_output_style, chopper_rate_sel, highway_signaling_en;
    logic master_clk_source, e1_mux_allowed, master_clk_sel_bad, robbed_bit_en;
    logic robbed_bit_active, idle_output_style, low_power_en, low_power_mode;
    logic [7:0] rb;
    int err_count = 0;
    int compares = 0;
    wire [7:0] cfg_seen = {irq_output_style, chopper_rate_sel, highway_signaling_en,
        master_clk_source, master_clk_rate_sel};
    wire [6:0] clk_seen = {tx_edge_sel, rx_clock_slot, tx_clock_slot};

    always #2.5 ref_clk = ~ref_clk;

    codec_setup uut (.*);
    host_model hst (.ref_clk(ref_clk), .host_cs_n(host_cs_n),
        .host_data_clock(host_data_clock), .host_din(host_din), .host_dout(host_dout));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check
    task automatic put(input logic [15:0] b, input int n = 8);
        hst.xfer(b, n, rb);
    endtask : put
    task automatic fs_pulse;
        frame_sync = 1'b1;
        hst.wait_clk(6);
        frame_sync = 1'b0;
        hst.wait_clk(6);
    endtask : fs_pulse
    task automatic print_verdict;
        $display("compares %0d, err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    task automatic t_reset;
        check("tx slots", tx_slot_byte, 32'h03020100);
        check("rx slots", rx_slot_byte, 32'h03020100);
        check("clk byte", clk_seen, 7'h00);
        check("cfg byte", cfg_seen, 8'h9a);
        check("khz", master_clk_khz, 14'd8192);
        check("enables", chan_cmd_en, 4'hf);
        check("active", channel_active_flag, 4'h0);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_config;
        logic [3:0] v;
        logic [13:0] khz;
        logic [3:0] vals [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h8, 4'hc};
        put(8'h4a);
        put(8'h00);
        check("no enables", chan_cmd_en, 4'h0);
        for (int i = 0; i < 7; i++)
        begin
            v = vals[i];
            khz = (v[1:0] == 2'd0) ? 14'd1536 : (v[1:0] == 2'd1) ? 14'd1544 : 14'd2048;
            khz = (v[1:0] == 2'd3 || v[3:2] == 2'd3) ? 14'd0 : khz << v[3:2];
            put(16'h0a46, 12);
            put({v, v});
            check("cfg", cfg_seen, {v, v});
            check("chopper", chopper_divisor, v[2] ? 4'd7 : 4'd8);
            check("e1 mux", e1_mux_allowed, v[0]);
            check("khz", master_clk_khz, khz);
            check("sel bad", master_clk_sel_bad, khz == 14'd0);
        end
        put(8'h03, 4);
        put(8'h47);
        put(8'h00);
        check("cfg read", rb, 8'hcc);
        $display("t_config done");
    endtask : t_config

    task automatic t_clock;
        put(8'h44);
        check("clk ignored", clk_seen, 7'h00);
        put(8'h4a);
        put(8'h05);
        put(8'h44);
        put(8'hd5);
        check("clk fields", clk_seen, 7'h55);
        check("dual a", tx_hwy_a_en, 4'hf);
        check("dual b", tx_hwy_b_en, 4'hf);
        put(8'h45);
        put(8'h00);
        check("clk read", rb, 8'hd5);
        $display("t_clock done");
    endtask : t_clock

    task automatic t_slots;
        put(8'h44);
        put(8'h00);
        put(8'h40);
        put(8'h85);
        put(8'h7f);
        check("tx slots", tx_slot_byte, 32'h037f0185);
        check("hwy a", tx_hwy_a_en, 4'he);
        check("hwy b", tx_hwy_b_en, 4'h1);
        put(8'h42);
        put(8'h80);
        put(8'h05);
        check("rx slots", rx_slot_byte, 32'h03050180);
        check("rx hwy", rx_highway_sel, 4'h1);
        put(8'h43);
        put(8'h00);
        check("rx rd ch1", rb, 8'h80);
        put(8'h00);
        check("rx rd ch3", rb, 8'h05);
        put(8'h41);
        check("oe idle", host_dout_oe, 1'b0);
        hst.select_low();
        check("dout oe", host_dout_oe, 1'b1);
        put(8'h00);
        check("rd ch1", rb, 8'h85);
        put(8'h00);
        check("rd ch3", rb, 8'h7f);
        $display("t_slots done");
    endtask : t_slots

    task automatic t_active;
        put(8'h4a);
        put(8'h75);
        check("modes", {robbed_bit_en, idle_output_style, low_power_en}, 3'h7);
        put(8'h4b);
        put(8'h00);
        check("en read", rb, 8'h75);
        check("lp mode", low_power_mode, 1'b1);
        check("hiz idle", analog_out_hiz, 4'hf);
        check("rb alaw", robbed_bit_active, 1'b0);
        mu_law_sel = 1'b1;
        hst.wait_clk(2);
        check("rb mulaw", robbed_bit_active, 1'b1);
        put(8'h06);
        check("nop act", channel_active_flag, 4'h0);
        check("nop slots", tx_slot_byte, 32'h037f0185);
        put(8'h0e);
        check("active", channel_active_flag, 4'h5);
        check("lp off", low_power_mode, 1'b0);
        check("hiz act", analog_out_hiz, 4'ha);
        fs_pulse();
        check("valid early", tx_pcm_valid, 4'h0);
        fs_pulse();
        check("valid", tx_pcm_valid, 4'h5);
        $display("t_active done");
    endtask : t_active

    task automatic t_serial_reset;
        put(16'hffff, 16);
        check("rst slots", tx_slot_byte, 32'h03020100);
        check("rst cfg", cfg_seen, 8'h9a);
        check("rst en", chan_cmd_en, 4'hf);
        check("rst act", channel_active_flag, 4'h0);
        $display("t_serial_reset done");
    endtask : t_serial_reset

    initial
    begin
        repeat (12) @(posedge ref_clk);
        #1;
        resetn = 1'b1;
        hst.wait_clk(4);
        t_reset();
        t_config();
        t_clock();
        t_slots();
        t_active();
        t_serial_reset();
        print_verdict();
    end
    // A hang ends the run as a mismatch
    initial
    begin
        repeat (100000) @(posedge ref_clk);
        err_count++;
        print_verdict();
    end
endmodule : tb_codec_setup
